/* core/io_bank.sv */
/*
  One I/O bank: power-up and configuration sequencing, pad gating and a
  row of programmable I/O cells sharing one freeze control.
  Assumes supply-good, config done and config error are synchronous levels.
*/
// Operation
// [R1] each cell has input, output, tri-state stages
// [R2] input stage samples pad before core
// [R3] output registered or passed, by configuration
// [R4] bank-wide freeze holds unregistered inputs
// [R5] hold control keeps core input at last value
// [R6] core stops capture enable for registered inputs
// [R7] pre-config pads tri-stated with pull-up until supplies
// [R8] pads tri-stated until configuration completes successfully
// [R9] unused pads blocked, pull-up off after configuration
// [R10] core inactive during power-on reset
// [R11] reset release starts flash configuration download
// [R12] enable low tri-states pad, high drives data
// [R13] registered interface style at data boundary
`timescale 1ns/1ps
module io_bank (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic supplies_ok_i,
  input wire logic cfg_done_i,
  input wire logic cfg_error_i,
  input wire logic clk_en_i,
  input wire logic capture_en_i,
  input wire logic launch_en_i,
  input wire logic hold_input_i,
  input wire logic [io_bank_pkg::PAD_COUNT-1:0] used_i,
  input wire logic [io_bank_pkg::PAD_COUNT-1:0] in_reg_i,
  input wire logic [io_bank_pkg::PAD_COUNT-1:0] out_reg_i,
  input wire logic [io_bank_pkg::PAD_COUNT-1:0] pullup_cfg_i,
  input wire logic [io_bank_pkg::PAD_COUNT-1:0] pad_in_i,
  input wire logic [io_bank_pkg::PAD_COUNT-1:0] dout_i,
  input wire logic [io_bank_pkg::PAD_COUNT-1:0] oe_i,
  output logic [io_bank_pkg::PAD_COUNT-1:0] din_o,
  output logic [io_bank_pkg::PAD_COUNT-1:0] pad_out_o,
  output logic [io_bank_pkg::PAD_COUNT-1:0] pad_oe_o,
  output logic [io_bank_pkg::PAD_COUNT-1:0] pad_pullup_o,
  output logic cfg_start_o,
  output logic core_active_o,
  output logic user_mode_o
);
  import io_bank_pkg::*;

  seq_state_t state_q, state_d;
  logic start_q, start_d;
  logic active_q, active_d;

  logic [PAD_COUNT-1:0] cell_din;
  logic [PAD_COUNT-1:0] cell_out;
  logic [PAD_COUNT-1:0] cell_oe;
  logic user;

  function automatic logic pad_live(input seq_state_t st, input logic used);
    pad_live = (st == SEQ_USER) && used;
  endfunction

  always_comb begin
    state_d = state_q;
    start_d = 1'b0;
    // [R10] core wakes only after reset release
    active_d = 1'b1;
    unique case (state_q)
      SEQ_WAIT_SUPPLY: begin
        // [R11] start download on valid supplies
        if (supplies_ok_i) begin
          state_d = SEQ_LOAD;
          start_d = 1'b1;
        end
      end
      SEQ_LOAD: begin
        if (!supplies_ok_i) begin
          state_d = SEQ_WAIT_SUPPLY;
        end else if (cfg_error_i) begin
          state_d = SEQ_FAILED;
        end else if (cfg_done_i) begin
          state_d = SEQ_USER;
        end
      end
      SEQ_USER: begin
        if (!supplies_ok_i) begin
          state_d = SEQ_WAIT_SUPPLY;
        end
      end
      SEQ_FAILED: begin
        if (!supplies_ok_i) begin
          state_d = SEQ_WAIT_SUPPLY;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= SEQ_RST;
      start_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      state_q <= state_d;
      start_q <= start_d;
      active_q <= active_d;
    end
  end

  assign user = (state_q == SEQ_USER);
  assign cfg_start_o = start_q;
  assign core_active_o = active_q;
  assign user_mode_o = user;

  genvar g;
  generate
    for (g = 0; g < PAD_COUNT; g++) begin : g_pad
      logic live;
      assign live = pad_live(state_q, used_i[g]);
      programmable_io_cell u_cell (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .active_i(pad_live(state_q, used_i[g])),
        .clk_en_i(clk_en_i),
        .capture_en_i(capture_en_i),
        .launch_en_i(launch_en_i),
        .in_reg_i(in_reg_i[g]),
        .out_reg_i(out_reg_i[g]),
        // [R5] one hold control for the bank
        .freeze_i(hold_input_i),
        .pad_in_i(pad_in_i[g]),
        .dout_i(dout_i[g]),
        .oe_i(oe_i[g]),
        .din_o(cell_din[g]),
        .pad_out_o(cell_out[g]),
        .pad_oe_o(cell_oe[g])
      );
      // [R9] unused pads blocked, no pull-up
      assign din_o[g] = pad_live(state_q, used_i[g]) & cell_din[g];
      // [R8] no drive before successful load
      assign pad_oe_o[g] = pad_live(state_q, used_i[g]) & cell_oe[g];
      assign pad_out_o[g] = pad_live(state_q, used_i[g]) & cell_out[g];
      // [R7] weak pull-up until user mode
      assign pad_pullup_o[g] = user ? (used_i[g] & pullup_cfg_i[g]) : PULLUP_ON;

      a_pad_capture: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R2]
        live && in_reg_i[g] && clk_en_i && capture_en_i ##1 live && in_reg_i[g] |-> din_o[g] == $past(pad_in_i[g]))
        else $error("registered pad input not captured");
      a_pad_reg_keep: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R6]
        live && in_reg_i[g] && !(clk_en_i && capture_en_i) ##1 live && in_reg_i[g] |-> $stable(din_o[g]))
        else $error("registered pad input moved without capture");
      a_pad_unreg: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R4]
        live && !in_reg_i[g] && !hold_input_i ##1 live && !in_reg_i[g] |-> din_o[g] == $past(pad_in_i[g]))
        else $error("unregistered pad input not followed");
      a_pad_pass: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R3]
        live && !out_reg_i[g] |-> pad_out_o[g] == dout_i[g])
        else $error("pass-through output wrong");
      a_pad_launch: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R3]
        live && out_reg_i[g] && clk_en_i && launch_en_i ##1 live && out_reg_i[g] |-> pad_out_o[g] == $past(dout_i[g]))
        else $error("registered output not launched");
      a_pad_oe_load: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R12]
        live && clk_en_i && launch_en_i ##1 live |-> pad_oe_o[g] == $past(oe_i[g]))
        else $error("pad enable not loaded");
      a_pad_oe_keep: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R12]
        live && !(clk_en_i && launch_en_i) ##1 live |-> $stable(pad_oe_o[g]))
        else $error("pad enable moved without launch");
      a_pad_idle: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R9]
        !live |-> !din_o[g] && !pad_oe_o[g] && !pad_out_o[g])
        else $error("idle pad not blocked");
    end
  endgenerate

  a_pullup_precfg: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R7]
    !user_mode_o |-> pad_pullup_o == '1 && pad_oe_o == '0)
    else $error("pad not tri-stated with pull-up before user mode");
  a_user_after_done: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R8]
    !user_mode_o ##1 user_mode_o |-> $past(cfg_done_i) && !$past(cfg_error_i))
    else $error("user mode without completed load");
  a_unused_block: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R9]
    user_mode_o |-> ((din_o | pad_oe_o | pad_pullup_o) & ~used_i) == '0)
    else $error("unused pad not blocked");
  a_core_wake: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R10]
    !core_active_o |=> core_active_o ##1 core_active_o)
    else $error("core did not wake after reset release");
  a_cfg_start: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R11]
    state_q == SEQ_WAIT_SUPPLY && supplies_ok_i |=> cfg_start_o && state_q == SEQ_LOAD ##1 !cfg_start_o)
    else $error("download start pulse wrong");
  // pads whose mode or use changes are not held
  a_hold_value: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R5]
    user_mode_o && hold_input_i ##1 user_mode_o && hold_input_i
    |-> ((din_o ^ $past(din_o)) & ~in_reg_i & ~$past(in_reg_i) & used_i & $past(used_i)) == '0)
    else $error("held input changed");
  a_supply_loss: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R7]
    !supplies_ok_i |=> state_q == SEQ_WAIT_SUPPLY && !user_mode_o)
    else $error("supply loss did not return to waiting");
  a_wait_no_user: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R7]
    state_q == SEQ_WAIT_SUPPLY |=> !user_mode_o)
    else $error("user mode straight from waiting");
  a_failed_stays: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R8]
    state_q == SEQ_FAILED && supplies_ok_i |=> state_q == SEQ_FAILED)
    else $error("failed load left without supply loss");
  a_error_wins: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R8]
    state_q == SEQ_LOAD && supplies_ok_i && cfg_error_i |=> state_q == SEQ_FAILED)
    else $error("load error not taken");
  a_done_to_user: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R8]
    state_q == SEQ_LOAD && supplies_ok_i && !cfg_error_i && cfg_done_i |=> user_mode_o)
    else $error("completed load did not enter user mode");
  a_user_stays: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R8]
    user_mode_o && supplies_ok_i |=> user_mode_o)
    else $error("user mode dropped with valid supplies");
  a_pre_user_quiet: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R8]
    !user_mode_o |-> din_o == '0 && pad_out_o == '0)
    else $error("pad data active before user mode");
  a_user_pullup: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R9]
    user_mode_o |-> pad_pullup_o == (used_i & pullup_cfg_i))
    else $error("user pull-up not as configured");
  a_core_stays: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R10]
    core_active_o |=> core_active_o)
    else $error("core went inactive without reset");
  a_no_stray_start: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R11]
    !(state_q == SEQ_WAIT_SUPPLY && supplies_ok_i) |=> !cfg_start_o)
    else $error("download start outside waiting");
  a_start_single: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R11]
    cfg_start_o |=> !cfg_start_o)
    else $error("download start longer than one cycle");

endmodule

/* inc/io_bank_pkg.sv */
/*
  Constants and types shared by the I/O bank and its programmable I/O cells.
  Assumes one 25 MHz clock and an active-high asynchronous power-on reset.
*/
package io_bank_pkg;

  // pads in one bank
  localparam int PAD_COUNT = 4;

  // value held in cell stages after reset
  localparam logic CELL_RST_VAL = 1'b0;
  // pull-up level before configuration
  localparam logic PULLUP_ON = 1'b1;

  // power-up / configuration sequence, gray coded along wait-load-user
  typedef enum logic [1:0] {
    SEQ_WAIT_SUPPLY = 2'b00,
    SEQ_LOAD = 2'b01,
    SEQ_USER = 2'b11,
    SEQ_FAILED = 2'b10
  } seq_state_t;

  localparam seq_state_t SEQ_RST = SEQ_WAIT_SUPPLY;

endpackage

/* core/programmable_io_cell.sv */
/*
  One programmable I/O cell: input capture stage, output launch stage,
  tri-state stage and the freeze hold for the unregistered input path.
  Assumes capture and launch ticks are one-cycle enables on ref_clk_i.
*/
`timescale 1ns/1ps
module programmable_io_cell (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic active_i,
  input wire logic clk_en_i,
  input wire logic capture_en_i,
  input wire logic launch_en_i,
  input wire logic in_reg_i,
  input wire logic out_reg_i,
  input wire logic freeze_i,
  input wire logic pad_in_i,
  input wire logic dout_i,
  input wire logic oe_i,
  output logic din_o,
  output logic pad_out_o,
  output logic pad_oe_o
);
  import io_bank_pkg::*;

  logic in_q, in_d;
  logic hold_q, hold_d;
  logic out_q, out_d;
  logic oe_q, oe_d;

  // [R1] four register stages: input, hold, output, tri-state
  always_comb begin
    in_d = in_q;
    hold_d = hold_q;
    out_d = out_q;
    oe_d = oe_q;
    if (!active_i) begin
      in_d = CELL_RST_VAL;
      hold_d = CELL_RST_VAL;
      out_d = CELL_RST_VAL;
      oe_d = CELL_RST_VAL;
    end else begin
      // [R2] capture pad input
      if (clk_en_i && capture_en_i) begin
        in_d = pad_in_i;
      end
      // [R4] freeze holds unregistered input
      if (!freeze_i) begin
        hold_d = pad_in_i;
      end
      if (clk_en_i && launch_en_i) begin
        out_d = dout_i;
        oe_d = oe_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      in_q <= CELL_RST_VAL;
      hold_q <= CELL_RST_VAL;
      out_q <= CELL_RST_VAL;
      oe_q <= CELL_RST_VAL;
    end else begin
      in_q <= in_d;
      hold_q <= hold_d;
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  // [R13] core sees a flop in either mode
  assign din_o = in_reg_i ? in_q : hold_q;
  // [R3] registered or pass-through output
  assign pad_out_o = out_reg_i ? out_q : dout_i;
  // [R12] tri-state from registered enable
  assign pad_oe_o = active_i & oe_q;

  a_in_capture: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R2]
    active_i && clk_en_i && capture_en_i ##1 active_i |-> in_q == $past(pad_in_i))
    else $error("input stage missed capture");
  a_out_launch: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R3]
    active_i && out_reg_i && clk_en_i && launch_en_i ##1 active_i && out_reg_i |-> pad_out_o == $past(dout_i))
    else $error("output stage missed launch");
  a_freeze_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R4]
    active_i && !in_reg_i && freeze_i ##1 active_i && !in_reg_i |-> $stable(din_o))
    else $error("frozen input changed");
  a_oe_tristate: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // [R12]
    active_i && clk_en_i && launch_en_i && !oe_i |=> !pad_oe_o)
    else $error("pad driven with enable low");

endmodule

/* verification/pad_board_model.sv */
/*
  board side of one bank: pad level from cell, board driver, pull-up.
  assumes the cell wins over the board driver.
*/
`timescale 1ns/1ps
module pad_board_model (
  input wire logic ref_clk_i,
  input wire logic [io_bank_pkg::PAD_COUNT-1:0] pad_out_i,
  input wire logic [io_bank_pkg::PAD_COUNT-1:0] pad_oe_i,
  input wire logic [io_bank_pkg::PAD_COUNT-1:0] pad_pullup_i,
  input wire logic [io_bank_pkg::PAD_COUNT-1:0] ext_en_i,
  input wire logic [io_bank_pkg::PAD_COUNT-1:0] ext_val_i,
  output logic [io_bank_pkg::PAD_COUNT-1:0] pad_level_o
);
  import io_bank_pkg::*;
  logic [PAD_COUNT-1:0] float_q = '0;
  // undriven pad wanders
  always @(negedge ref_clk_i) begin
    float_q <= ~float_q;
  end
  always_comb begin
    pad_level_o = pad_pullup_i | float_q;
    pad_level_o = (ext_en_i & ext_val_i) | (~ext_en_i & pad_level_o);
    pad_level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & pad_level_o);
  end
endmodule

/* verification/io_bank_tb.sv */
/*
  random and directed bench for one bank.
  assumes one-cycle stage latency.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module io_bank_tb;
  import io_bank_pkg::*;
  localparam int N = PAD_COUNT;
  logic ref_clk_i = 0, sys_rst_i = 1, sup = 0, done = 0, err = 0, clk_en = 0, cap = 0, lau = 0, hold = 0;
  logic [N-1:0] used = '0, in_reg = '0, out_reg = '0, pu_cfg = '0, dout = '0, oe = '0, x_en = '0, x_val = '0;
  logic [N-1:0] pad_in, din, pad_out, pad_oe, pull, live;
  logic [N-1:0] cap_q = '0, frz_q = '0, dat_q = '0, oe_q = '0;
  logic start, active, user, in_user = 0;
  int n_errors = 0, n_compared = 0, seed = 32'h2340228C;
  io_bank io_bank_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .supplies_ok_i(sup), .cfg_done_i(done),
    .cfg_error_i(err), .clk_en_i(clk_en), .capture_en_i(cap), .launch_en_i(lau), .hold_input_i(hold),
    .used_i(used), .in_reg_i(in_reg), .out_reg_i(out_reg), .pullup_cfg_i(pu_cfg), .pad_in_i(pad_in),
    .dout_i(dout), .oe_i(oe), .din_o(din), .pad_out_o(pad_out), .pad_oe_o(pad_oe), .pad_pullup_o(pull),
    .cfg_start_o(start), .core_active_o(active), .user_mode_o(user));
  pad_board_model pad_board_model_i (.ref_clk_i(ref_clk_i), .pad_out_i(pad_out), .pad_oe_i(pad_oe),
    .pad_pullup_i(pull), .ext_en_i(x_en), .ext_val_i(x_val), .pad_level_o(pad_in));
  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // expected stages
  always @(posedge ref_clk_i) begin
    live = in_user ? used : '0;
    cap_q <= live & ((clk_en & cap) ? pad_in : cap_q);
    frz_q <= live & (hold ? frz_q : pad_in);
    dat_q <= live & ((clk_en & lau) ? dout : dat_q);
    oe_q <= live & ((clk_en & lau) ? oe : oe_q);
  end
  task automatic tick();
    @(negedge ref_clk_i);
  endtask
  task automatic close_out();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cells();
    logic [N-1:0] lv;
    lv = in_user ? used : '0;
    `CHK("din", lv & ((in_reg & cap_q) | (~in_reg & frz_q)), din)
    `CHK("pad_out", lv & ((out_reg & dat_q) | (~out_reg & dout)), pad_out)
    `CHK("pad_oe", lv & oe_q, pad_oe)
    `CHK("pullup", in_user ? (used & pu_cfg) : {N{PULLUP_ON}}, pull)
  endtask
  task automatic drive();
    {clk_en, cap, lau, hold} = 4'($random(seed));
    {used, in_reg, out_reg, pu_cfg} = (4*N)'($random(seed));
    {dout, oe, x_en, x_val} = (4*N)'($random(seed));
  endtask
  initial begin
    #2000000 n_errors++;
    close_out();
  end
  initial begin
    repeat (5) tick();
    `CHK("reset", {2'b00, {N{PULLUP_ON}}}, {active, start, pull})
    sys_rst_i = 0;
    done = 1;
    repeat (3) begin
      drive();
      tick();
      `CHK("active", 1'b1, active)
      cells();
    end
    done = 0;
    sup = 1;
    tick();
    `CHK("start", 1'b1, start)
    err = 1;
    done = 1;
    repeat (3) tick();
    `CHK("failed", 2'b00, {start, user})
    cells();
    err = 0;
    sup = 0;
    tick();
    sup = 1;
    done = 0;
    tick();
    `CHK("restart", 2'b10, {start, user})
    done = 1;
    tick();
    `CHK("user", 1'b1, user)
    in_user = 1;
    repeat (400) begin
      cells();
      drive();
      tick();
    end
    sup = 0;
    tick();
    in_user = 0;
    cells();
    close_out();
  end
endmodule
